// File: hw/clock_watchdog_recovery.sv
/*
  Watchdog, recovery frequency and programmed cpu frequency of a clock
  synthesizer. Control bytes arrive as write strobes from the serial-bus
  slave on the same clock; the strap pins come from outside and are
  synchronised. The cpu frequency is reported in units of 10 Hz.
*/
// Behaviour
// - arm written 0 stops watchdog, reloads count, leaves locked recovery mode.
// - armed watchdog starts counting only after an output frequency change.
// - time-out issues system reset if enabled, loads recovery frequency, locks recovery mode.
// - while locked, frequency-changing writes are ignored until arm is cleared.
// - time-out flag reads 1 after time-out; write 1 clears, 0 ignored.
// - 5-bit time-out value in units; short unit 150 ms spans 150 ms-4.8 s.
// - long unit 2.5 s spans 2.5 s to 80 s.
// - counter reaching zero sets the time-out flag.
// - reset pulse on time-out only when reset-on-time-out enable is 1.
// - reset pulse on frequency change only when reset-on-change enable is 1.
// - programmed cpu frequency is gear times (n+3) divided by (m+3).
// - gear constant follows the strap or software frequency code.
// - recovery frequency from latched strap code, or recovery n and m.
`timescale 1ns/100ps
module clock_watchdog_recovery
  import wdt_recovery_pkg::*;
#(
  parameter int UNIT_SHORT_CYCLES = UNIT_SHORT_CYC,
  parameter int UNIT_LONG_CYCLES = UNIT_LONG_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [CODE_W-1:0] i_strap_frequency_code,
  input wire logic i_ctrl_wr,
  input wire logic i_watchdog_arm,
  input wire logic i_timeout_flag_clear,
  input wire logic [TVAL_W-1:0] i_timeout_value,
  input wire logic i_timeout_unit_select,
  input wire logic i_reset_on_timeout_enable,
  input wire logic i_reset_on_freq_change_enable,
  input wire logic i_recovery_source_select,
  input wire logic [N_W-1:0] i_recovery_n,
  input wire logic [M_W-1:0] i_recovery_m,
  input wire logic i_freq_wr,
  input wire logic i_prog_freq_enable,
  input wire logic i_freq_override,
  input wire logic [CODE_W-1:0] i_sel_code,
  input wire logic [N_W-1:0] i_prog_n,
  input wire logic [M_W-1:0] i_prog_m,
  output logic o_watchdog_arm,
  output logic o_timeout_flag,
  output logic [TVAL_W-1:0] o_timeout_value,
  output logic o_timeout_unit_select,
  output logic o_reset_on_timeout_enable,
  output logic o_reset_on_freq_change_enable,
  output logic o_recovery_source_select,
  output logic o_recovery_locked,
  output logic o_wd_counting,
  output logic [CODE_W-1:0] o_strap_frequency_code,
  output logic [CODE_W-1:0] o_active_code,
  output logic o_active_prog,
  output logic [FREQ_W-1:0] o_cpu_freq_10hz,
  output logic o_cpu_freq_valid,
  output logic o_sys_reset
);
  typedef struct packed {
    logic [CODE_W-1:0] strap_meta;
    logic [CODE_W-1:0] strap_sync;
    logic [1:0] strap_age;
    logic [CODE_W-1:0] strap_code;
    logic arm;
    logic flag;
    logic [TVAL_W-1:0] tval;
    logic unit_sel;
    logic to_en;
    logic fc_en;
    logic rec_src;
    logic [N_W-1:0] rec_n;
    logic [M_W-1:0] rec_m;
    logic act_prog;
    logic [CODE_W-1:0] act_code;
    logic [N_W-1:0] act_n;
    logic [M_W-1:0] act_m;
    logic locked;
    logic counting;
    logic [5:0] wd_cnt;
    logic [27:0] unit_cnt;
    logic [4:0] rst_cnt;
    logic sys_rst;
    logic div_go;
    logic [FREQ_W-1:0] freq;
    logic freq_valid;
  } wd_state_t;

  wd_state_t st_r;
  wd_state_t st_nxt;
  logic [FREQ_W-1:0] div_quo;
  logic div_done;
  logic [27:0] unit_last;
  logic tick;
  logic timeout;
  logic fchg;
  logic [CODE_W-1:0] new_code;
  logic [23:0] gear;
  logic [FREQ_W-1:0] dividend;
  logic [7:0] divisor;

  // gear constant of a frequency code
  function automatic logic [23:0] gear_of(input logic [CODE_W-1:0] code);
    logic [23:0] g;
    unique case (code)
      CODE_GEAR_G1: g = GEAR_G1;
      CODE_GEAR_G2: g = GEAR_G2;
      default: g = GEAR_G3;
    endcase
    return g;
  endfunction

  // long cycle counts kept as parameters so a simulation can shrink them
  assign unit_last = st_r.unit_sel ? 28'(UNIT_LONG_CYCLES - 1)
                                   : 28'(UNIT_SHORT_CYCLES - 1);
  assign tick = st_r.counting && (st_r.unit_cnt == unit_last);

  // divider operands come from the registered active setting
  assign gear = gear_of(st_r.act_code);
  assign dividend = 32'(gear) * 32'({1'b0, st_r.act_n} + 9'(NM_OFFSET));
  assign divisor = {1'b0, st_r.act_m} + 8'(NM_OFFSET);

  always_comb begin
    st_nxt = st_r;
    st_nxt.div_go = 1'b0;
    timeout = 1'b0;
    fchg = 1'b0;
    new_code = st_r.act_code;
    // strap pins: two flops, then latched once after release
    st_nxt.strap_meta = i_strap_frequency_code;
    st_nxt.strap_sync = st_r.strap_meta;
    if (st_r.strap_age != STRAP_SETTLE) begin
      st_nxt.strap_age = st_r.strap_age + 2'h1;
      if (st_r.strap_age == STRAP_SETTLE - 2'h1) begin
        st_nxt.strap_code = st_r.strap_sync;
        st_nxt.act_code = st_r.strap_sync;
        st_nxt.div_go = 1'b1;
      end
    end
    // reset pulse countdown
    if (st_r.rst_cnt != 5'h00) begin
      st_nxt.rst_cnt = st_r.rst_cnt - 5'h01;
    end
    // unit prescaler and watchdog countdown
    if (st_r.counting) begin
      st_nxt.unit_cnt = tick ? 28'h0000000 : st_r.unit_cnt + 28'h0000001;
      if (tick) begin
        st_nxt.wd_cnt = st_r.wd_cnt - 6'h01;
        timeout = (st_r.wd_cnt == 6'h01);
      end
    end
    // control byte write
    if (i_ctrl_wr) begin
      st_nxt.arm = i_watchdog_arm;
      st_nxt.tval = i_timeout_value;
      st_nxt.unit_sel = i_timeout_unit_select;
      st_nxt.to_en = i_reset_on_timeout_enable;
      st_nxt.fc_en = i_reset_on_freq_change_enable;
      st_nxt.rec_src = i_recovery_source_select;
      st_nxt.rec_n = i_recovery_n;
      st_nxt.rec_m = i_recovery_m;
      if (i_timeout_flag_clear) begin
        st_nxt.flag = 1'b0;
      end
      if (!i_watchdog_arm) begin
        st_nxt.counting = 1'b0;
        st_nxt.wd_cnt = {1'b0, i_timeout_value} + 6'h01;
        st_nxt.unit_cnt = 28'h0000000;
        st_nxt.locked = 1'b0;
      end
    end
    // frequency write, dropped while locked
    if (i_freq_wr && !st_r.locked) begin
      new_code = i_freq_override ? i_sel_code : st_r.strap_code;
      fchg = (i_prog_freq_enable != st_r.act_prog) || (new_code != st_r.act_code)
          || (i_prog_freq_enable && ((i_prog_n != st_r.act_n) || (i_prog_m != st_r.act_m)));
      st_nxt.act_prog = i_prog_freq_enable;
      st_nxt.act_code = new_code;
      st_nxt.act_n = i_prog_n;
      st_nxt.act_m = i_prog_m;
    end
    if (fchg) begin
      st_nxt.div_go = 1'b1;
      if (st_r.fc_en) begin
        st_nxt.rst_cnt = 5'(RESET_PULSE_CYC);
      end
      // each change opens a fresh window when armed
      if (st_nxt.arm) begin
        st_nxt.counting = 1'b1;
        st_nxt.wd_cnt = {1'b0, st_nxt.tval} + 6'h01;
        st_nxt.unit_cnt = 28'h0000000;
      end
    end
    // time-out: set wins over a clear in the same cycle
    if (timeout) begin
      st_nxt.flag = 1'b1;
      if (st_nxt.arm) begin
        st_nxt.counting = 1'b0;
        st_nxt.wd_cnt = 6'h00;
        st_nxt.locked = 1'b1;
        st_nxt.div_go = 1'b1;
        if (st_r.to_en) begin
          st_nxt.rst_cnt = 5'(RESET_PULSE_CYC);
        end
        if (st_nxt.rec_src) begin
          st_nxt.act_prog = 1'b1;
          st_nxt.act_n = st_nxt.rec_n;
          st_nxt.act_m = st_nxt.rec_m;
        end else begin
          st_nxt.act_prog = 1'b0;
          st_nxt.act_code = st_r.strap_code;
        end
      end
    end
    st_nxt.sys_rst = (st_nxt.rst_cnt != 5'h00);
    // frequency result
    if (st_r.div_go) begin
      st_nxt.freq_valid = 1'b0;
    end else if (div_done) begin
      st_nxt.freq = div_quo;
      st_nxt.freq_valid = st_r.act_prog;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
      st_r.arm <= RST_ARM;
      st_r.flag <= RST_FLAG;
      st_r.tval <= RST_TVAL;
      st_r.unit_sel <= RST_UNIT_SEL;
      st_r.to_en <= RST_TO_EN;
      st_r.fc_en <= RST_FC_EN;
      st_r.rec_src <= RST_REC_SRC;
      st_r.act_prog <= RST_PROG_EN;
      st_r.wd_cnt <= {1'b0, RST_TVAL} + 6'h01;
    end else begin
      st_r <= st_nxt;
    end
  end

  // a restart aborts a stale division, so only the latest setting lands
  freq_divider u_div (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_start(st_r.div_go),
    .i_dividend(dividend),
    .i_divisor(divisor),
    .o_quotient(div_quo),
    .o_done(div_done)
  );

  // all outputs straight from state flops
  assign o_watchdog_arm = st_r.arm;
  assign o_timeout_flag = st_r.flag;
  assign o_timeout_value = st_r.tval;
  assign o_timeout_unit_select = st_r.unit_sel;
  assign o_reset_on_timeout_enable = st_r.to_en;
  assign o_reset_on_freq_change_enable = st_r.fc_en;
  assign o_recovery_source_select = st_r.rec_src;
  assign o_recovery_locked = st_r.locked;
  assign o_wd_counting = st_r.counting;
  assign o_strap_frequency_code = st_r.strap_code;
  assign o_active_code = st_r.act_code;
  assign o_active_prog = st_r.act_prog;
  assign o_cpu_freq_10hz = st_r.freq;
  assign o_cpu_freq_valid = st_r.freq_valid;
  assign o_sys_reset = st_r.sys_rst;
endmodule

// File: hw/freq_divider.sv
/*
  Serial restoring divider, one quotient bit per cycle, 32 cycles a result.
  Assumes start is a one-cycle pulse on the same clock; a new start aborts
  any division in progress.
*/
`timescale 1ns/100ps
module freq_divider
  import wdt_recovery_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire logic [FREQ_W-1:0] i_dividend,
  input wire logic [7:0] i_divisor,
  output logic [FREQ_W-1:0] o_quotient,
  output logic o_done
);
  typedef struct packed {
    logic busy;
    logic [5:0] cnt;
    logic [8:0] rem;
    logic [FREQ_W-1:0] quo;
    logic done;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;
  logic [8:0] rem_sh;

  // one restoring step per cycle while busy
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    rem_sh = {st_r.rem[7:0], st_r.quo[FREQ_W-1]};
    if (i_start) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt = 6'h00;
      st_nxt.rem = 9'h000;
      st_nxt.quo = i_dividend;
    end else if (st_r.busy) begin
      st_nxt.quo = {st_r.quo[FREQ_W-2:0], 1'b0};
      st_nxt.rem = rem_sh;
      if (rem_sh >= {1'b0, i_divisor}) begin
        st_nxt.rem = rem_sh - {1'b0, i_divisor};
        st_nxt.quo[0] = 1'b1;
      end
      st_nxt.cnt = st_r.cnt + 6'h01;
      if (st_r.cnt == 6'h1f) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_quotient = st_r.quo;
  assign o_done = st_r.done;
endmodule

// File: hw/wdt_recovery_pkg.sv
/*
  Shared constants for the clock watchdog and recovery logic: timing units,
  gear constants, field widths and reset values.
  Assumes a single 100 MHz core clock.
*/
package wdt_recovery_pkg;
  // core clock
  localparam int CLK_MHZ = 100;
  // watchdog units, as printed
  localparam int UNIT_SHORT_MS = 150;
  localparam int UNIT_LONG_MS = 2500;
  localparam int UNIT_SHORT_CYC = UNIT_SHORT_MS * 1000 * CLK_MHZ;
  localparam int UNIT_LONG_CYC = UNIT_LONG_MS * 1000 * CLK_MHZ;
  // system reset pulse length
  localparam int RESET_PULSE_NS = 200;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  // strap sampling: edges after reset release before the strap is latched
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // gear constants in units of 10 Hz
  localparam logic [23:0] GEAR_G1 = 24'h30d5ee; // 32.00494 MHz
  localparam logic [23:0] GEAR_G2 = 24'h4940e5; // 48.00741 MHz
  localparam logic [23:0] GEAR_G3 = 24'h61abdc; // 64.00988 MHz
  localparam logic [23:0] GEAR_G4 = 24'h9281ca; // 96.01482 MHz
  // frequency codes with a non-default gear
  localparam logic [4:0] CODE_GEAR_G1 = 5'h1c;
  localparam logic [4:0] CODE_GEAR_G2 = 5'h1d;
  // offset added to n and m in the frequency equation
  localparam int NM_OFFSET = 3;
  // field widths
  localparam int TVAL_W = 5;
  localparam int CODE_W = 5;
  localparam int N_W = 8;
  localparam int M_W = 7;
  localparam int FREQ_W = 32;
  // reset values of the control bits
  localparam logic RST_ARM = 1'b0;
  localparam logic RST_FLAG = 1'b0;
  localparam logic [4:0] RST_TVAL = 5'h00;
  localparam logic RST_UNIT_SEL = 1'b0;
  localparam logic RST_TO_EN = 1'b0;
  localparam logic RST_FC_EN = 1'b0;
  localparam logic RST_REC_SRC = 1'b0;
  localparam logic RST_PROG_EN = 1'b0;
  localparam logic RST_OVERRIDE = 1'b0;
endpackage

// File: test/clock_watchdog_recovery_sva.sv
/*
  Port checker for the watchdog block: lock, flag, pulse and start rules.
  Assumes one core clock and an active-low async reset; bound to the top.
*/
`timescale 1ns/100ps
module clock_watchdog_recovery_sva
  import wdt_recovery_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_ctrl_wr,
  input wire logic i_watchdog_arm,
  input wire logic i_timeout_flag_clear,
  input wire logic i_freq_wr,
  input wire logic i_prog_freq_enable,
  input wire logic o_watchdog_arm,
  input wire logic o_timeout_flag,
  input wire logic o_reset_on_timeout_enable,
  input wire logic o_reset_on_freq_change_enable,
  input wire logic o_recovery_locked,
  input wire logic o_wd_counting,
  input wire logic [CODE_W-1:0] o_active_code,
  input wire logic o_active_prog,
  input wire logic o_sys_reset
);
  logic [7:0] plen_r;
  // pulse length counter; 20 cycles is too long for a repetition
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      plen_r <= 8'h00;
    end else begin
      plen_r <= o_sys_reset ? plen_r + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // a write that really changes the frequency in force
  sequence s_change;
    i_freq_wr && !i_ctrl_wr && !o_recovery_locked && (i_prog_freq_enable != o_active_prog);
  endsequence
  sequence s_lock;
    $rose(o_recovery_locked);
  endsequence
  property p_disarm;
    i_ctrl_wr && !i_watchdog_arm |=> !o_wd_counting && !o_recovery_locked;
  endproperty
  property p_no_start;
    !o_wd_counting && !i_freq_wr |=> !o_wd_counting;
  endproperty
  property p_arm_start;
    s_change ##0 o_watchdog_arm |=> o_wd_counting;
  endproperty
  property p_timeout;
    $fell(o_wd_counting) && o_watchdog_arm |-> o_timeout_flag && o_recovery_locked;
  endproperty
  property p_refuse;
    o_recovery_locked && i_freq_wr && !i_ctrl_wr |=> $stable(o_active_code) && $stable(o_active_prog);
  endproperty
  property p_flag_clear;
    i_ctrl_wr && i_timeout_flag_clear && !o_wd_counting |=> !o_timeout_flag;
  endproperty
  property p_flag_keep;
    o_timeout_flag && !(i_ctrl_wr && i_timeout_flag_clear) |=> o_timeout_flag;
  endproperty
  property p_to_pulse;
    s_lock ##0 o_reset_on_timeout_enable |-> ##[0:1] o_sys_reset;
  endproperty
  property p_to_quiet;
    s_lock ##0 (!o_reset_on_timeout_enable && !$past(o_sys_reset)) |-> !o_sys_reset ##1 !o_sys_reset;
  endproperty
  property p_fc_pulse;
    s_change ##0 o_reset_on_freq_change_enable |=> o_sys_reset;
  endproperty
  property p_fc_quiet;
    i_freq_wr && !i_ctrl_wr && !o_reset_on_freq_change_enable && !o_sys_reset && !o_wd_counting
      |=> !o_sys_reset;
  endproperty
  property p_pulse_len;
    $fell(o_sys_reset) |-> plen_r == 8'(RESET_PULSE_CYC);
  endproperty
  a_disarm: assert property (p_disarm) else $error("disarm left lock or count");
  a_no_start: assert property (p_no_start) else $error("count began without change");
  a_arm_start: assert property (p_arm_start) else $error("count not begun");
  a_timeout: assert property (p_timeout) else $error("time-out effects missing");
  a_refuse: assert property (p_refuse) else $error("locked write took effect");
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
  a_flag_keep: assert property (p_flag_keep) else $error("flag lost");
  a_to_pulse: assert property (p_to_pulse) else $error("no time-out pulse");
  a_to_quiet: assert property (p_to_quiet) else $error("unwanted time-out pulse");
  a_fc_pulse: assert property (p_fc_pulse) else $error("no change pulse");
  a_fc_quiet: assert property (p_fc_quiet) else $error("unwanted change pulse");
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
endmodule

bind clock_watchdog_recovery clock_watchdog_recovery_sva i_clock_watchdog_recovery_sva (.*);

// File: test/clock_watchdog_recovery_tb.sv
/*
  Self-checking bench for the watchdog block with short watchdog units.
  Assumes the host model drives all write strobes; recovery n/m are fixed.
*/
`timescale 1ns/100ps
module clock_watchdog_recovery_tb;
  import wdt_recovery_pkg::*;
  localparam int US = 10;
  localparam int UL = 20;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [CODE_W-1:0] i_strap_frequency_code = 5'h00;
  logic [N_W-1:0] i_recovery_n = 8'h5a;
  logic [M_W-1:0] i_recovery_m = 7'h2a;
  logic i_ctrl_wr, i_watchdog_arm, i_timeout_flag_clear, i_timeout_unit_select;
  logic i_reset_on_timeout_enable, i_reset_on_freq_change_enable, i_recovery_source_select;
  logic i_freq_wr, i_prog_freq_enable, i_freq_override;
  logic [TVAL_W-1:0] i_timeout_value, o_timeout_value;
  logic [CODE_W-1:0] i_sel_code, o_strap_frequency_code, o_active_code;
  logic [N_W-1:0] i_prog_n;
  logic [M_W-1:0] i_prog_m;
  logic o_watchdog_arm, o_timeout_flag, o_timeout_unit_select, o_reset_on_timeout_enable;
  logic o_reset_on_freq_change_enable, o_recovery_source_select, o_recovery_locked;
  logic o_wd_counting, o_active_prog, o_cpu_freq_valid, o_sys_reset;
  logic [FREQ_W-1:0] o_cpu_freq_10hz;
  int seed = 38;
  int fails = 0;
  int total_checks = 0;
  int cnt, ex;
  logic [4:0] code, tv;
  logic [7:0] n;
  logic [6:0] m;

  always #5 i_core_clk = ~i_core_clk;

  clock_watchdog_recovery #(.UNIT_SHORT_CYCLES(US), .UNIT_LONG_CYCLES(UL))
    i_clock_watchdog_recovery (.*);
  host_fw_model i_host_fw_model (.i_core_clk(i_core_clk), .o_ctrl_wr(i_ctrl_wr),
    .o_arm(i_watchdog_arm), .o_clear(i_timeout_flag_clear), .o_tval(i_timeout_value),
    .o_unit(i_timeout_unit_select), .o_to_en(i_reset_on_timeout_enable),
    .o_fc_en(i_reset_on_freq_change_enable), .o_src(i_recovery_source_select),
    .o_freq_wr(i_freq_wr), .o_prog(i_prog_freq_enable), .o_ovr(i_freq_override),
    .o_sel(i_sel_code), .o_n(i_prog_n), .o_m(i_prog_m));

  // gear by code, then g*(n+3)/(m+3) in 10 Hz units
  function automatic logic [31:0] exp_freq(input logic [4:0] c, input logic [7:0] nn,
                                           input logic [6:0] mm);
    logic [63:0] g;
    g = (c == CODE_GEAR_G1) ? 64'(GEAR_G1) : (c == CODE_GEAR_G2) ? 64'(GEAR_G2) : 64'(GEAR_G3);
    return 32'((g * (64'(nn) + 64'(NM_OFFSET))) / (64'(mm) + 64'(NM_OFFSET)));
  endfunction
  task automatic step(input int k);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic ctl(input logic a, c, input logic [4:0] t, input logic u, te, fe, s);
    i_host_fw_model.ctrl(a, c, t, u, te, fe, s);
    step(1);
  endtask
  task automatic fw(input logic p, input logic [4:0] s);
    i_host_fw_model.fwr(p, 1'b1, s, n, m);
    step(1);
  endtask
  task automatic final_report();
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence: reset, gear table, then watchdog round trips
  initial begin
    i_strap_frequency_code = 5'($random(seed));
    repeat (5) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    step(5);
    chk({o_watchdog_arm, o_timeout_flag, o_timeout_value, o_timeout_unit_select},
        {RST_ARM, RST_FLAG, RST_TVAL, RST_UNIT_SEL}, "reset");
    chk(o_strap_frequency_code, i_strap_frequency_code, "strap");
    for (int k = 0; k < 6; k++) begin
      code = (k == 0) ? CODE_GEAR_G1 : (k == 1) ? CODE_GEAR_G2 : 5'($random(seed));
      n = 8'(77 + {$random(seed)} % 30);
      m = 7'(39 + {$random(seed)} % 10);
      ctl(1'b0, 1'b0, 5'h00, 1'b0, 1'b0, 1'(k), 1'b0);
      fw(1'b0, code);
      chk({o_active_prog, o_active_code, o_sys_reset}, {1'b0, code, 1'(k)}, "change");
      step(40);
      fw(1'b1, code);
      step(40);
      chk(o_cpu_freq_valid, 1'b1, "valid");
      chk(o_cpu_freq_10hz, exp_freq(code, n, m), "freq");
    end
    // software code off: gear falls back to the latched strap, ratio stays n and m
    i_host_fw_model.fwr(1'b1, 1'b0, code, n, m);
    step(40);
    chk(o_active_code, i_strap_frequency_code, "strap select");
    chk(o_cpu_freq_10hz, exp_freq(i_strap_frequency_code, n, m), "strap freq");
    for (int k = 0; k < 4; k++) begin
      tv = (k == 0) ? 5'h00 : 5'($random(seed)) & 5'h03;
      ctl(1'b1, 1'b0, tv, k[0], k[1], 1'b0, k[1]);
      step(5);
      // readback of every control field just written
      chk({o_watchdog_arm, o_timeout_value, o_timeout_unit_select, o_reset_on_timeout_enable,
           o_reset_on_freq_change_enable, o_recovery_source_select},
          {1'b1, tv, k[0], k[1], 1'b0, k[1]}, "readback");
      chk(o_wd_counting, 1'b0, "armed idle");
      fw(~o_active_prog, code);
      ex = (int'(tv) + 1) * (k[0] ? UL : US) + 1;
      for (cnt = 1; cnt < 400 && o_timeout_flag !== 1'b1; cnt++) step(1);
      chk(32'(cnt >= ex - 1 && cnt <= ex + 1), 32'h1, "period");
      if (cnt >= 400) final_report();
      chk({o_recovery_locked, o_active_prog}, {1'b1, k[1]}, "locked");
      step(40);
      if (k[1]) begin
        chk(o_cpu_freq_10hz, exp_freq(code, i_recovery_n, i_recovery_m), "rec freq");
      end else begin
        chk(o_active_code, i_strap_frequency_code, "rec strap");
      end
      fw(~k[1], code ^ 5'h01);
      chk({o_active_prog, o_active_code}, {k[1], k[1] ? code : i_strap_frequency_code},
          "refused");
      ctl(1'b1, 1'b0, tv, k[0], k[1], 1'b0, k[1]);
      chk(o_timeout_flag, 1'b1, "flag kept");
      ctl(1'b0, 1'b1, tv, k[0], k[1], 1'b0, k[1]);
      chk({o_timeout_flag, o_recovery_locked, o_wd_counting}, 3'h0, "disarm");
    end
    final_report();
  end
endmodule

// File: test/host_fw_model.sv
/*
  Host firmware model: control and frequency writes as one-cycle strobes.
  Assumes the block takes a strobe at the next rising edge.
*/
`timescale 1ns/100ps
module host_fw_model
  import wdt_recovery_pkg::*;
(
  input wire logic i_core_clk,
  output logic o_ctrl_wr,
  output logic o_arm,
  output logic o_clear,
  output logic [TVAL_W-1:0] o_tval,
  output logic o_unit,
  output logic o_to_en,
  output logic o_fc_en,
  output logic o_src,
  output logic o_freq_wr,
  output logic o_prog,
  output logic o_ovr,
  output logic [CODE_W-1:0] o_sel,
  output logic [N_W-1:0] o_n,
  output logic [M_W-1:0] o_m
);
  // quiet bus at time zero
  initial begin
    {o_ctrl_wr, o_arm, o_clear, o_tval, o_unit, o_to_en, o_fc_en, o_src} = '0;
    {o_freq_wr, o_prog, o_ovr, o_sel, o_n, o_m} = '0;
  end
  // whole control byte in one strobe; fields held afterwards
  task automatic ctrl(input logic a, c, input logic [4:0] t, input logic u, te, fe, s);
    @(posedge i_core_clk);
    {o_arm, o_clear, o_tval, o_unit, o_to_en, o_fc_en, o_src} <= {a, c, t, u, te, fe, s};
    o_ctrl_wr <= 1'b1;
    @(posedge i_core_clk);
    o_ctrl_wr <= 1'b0;
  endtask
  // n and m go together so no half-written divisor is ever loaded
  task automatic fwr(input logic p, o, input logic [4:0] s, input logic [7:0] n, input logic [6:0] m);
    @(posedge i_core_clk);
    {o_prog, o_ovr, o_sel, o_n, o_m} <= {p, o, s, n, m};
    o_freq_wr <= 1'b1;
    @(posedge i_core_clk);
    o_freq_wr <= 1'b0;
  endtask
endmodule
